// ===== rtl/dacmc_defines.vh
// Offsets, field positions, reset value, write mask, interpolation codes and divider width for the datapath
// main control register block. Included by dacmc_main_control.v.
`ifndef DACMC_DEFINES_VH
`define DACMC_DEFINES_VH
`define DACMC_CTRL_OFFSET 8'h00
`define DACMC_CTRL_RESET 16'h049C
`define DACMC_CTRL_WMASK 16'hAF9E
`define DACMC_BIT_QMC_OFFSET 15
`define DACMC_BIT_QMC_CORR 13
`define DACMC_INTERP_HI 11
`define DACMC_INTERP_LO 8
`define DACMC_BIT_FIFO 7
`define DACMC_BIT_FAULT_OE 4
`define DACMC_BIT_FAULT_POL 3
`define DACMC_BIT_DIV_SYNC 2
`define DACMC_BIT_INVSINC 1
`define DACMC_INTERP_1X 4'h0
`define DACMC_INTERP_2X 4'h1
`define DACMC_INTERP_4X 4'h2
`define DACMC_INTERP_8X 4'h4
`define DACMC_INTERP_16X 4'h8
`define DACMC_DIV_WIDTH 4
`endif

// ===== rtl/dacmc_main_control.v
// Datapath main control register with AHB-Lite slave and control decode.
// Assumes one AHB-Lite master on clk; sync source arrives from outside.
//
// Notes on behaviour
// - Control register resets to 0x049C, all fields at defaults.
// - Bit 15 enables quadrature offset correction, else bypassed.
// - Bit 13 enables quadrature phase and gain correction.
// - Bits 11:8 pick interpolation 2x,4x,8x,16x by one-hot code, 1x by code 0000.
// - Interpolation field resets to code 0100, ratio eight.
// - Bit 7 routes samples through input FIFO, else bypass.
// - Bit 4 drives the fault pin, else pin is high impedance.
// - Bit 3 sets fault polarity: zero active-low, one active-high.
// - Bit 2 lets a syncIn rising edge resync the clock divider.
// - After sync all divided clocks are phase aligned.
// - Bit 1 inserts inverse-sinc filter, else bypassed.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "dacmc_defines.vh"
module dacmc_main_control #(
    parameter DIV_WIDTH = `DACMC_DIV_WIDTH
) (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire syncIn,
    input wire faultIn,
    output wire faultOut,
    output wire faultOutEn_n,
    output reg qmcOffsetEn,
    output reg qmcCorrEn,
    output reg [4:0] interpRatio,
    output reg interpBad,
    output reg fifoEn,
    output reg invSincEn,
    output reg [DIV_WIDTH-1:0] div0Phase,
    output reg [DIV_WIDTH-1:0] div1Phase,
    output reg syncSeen
);
    reg [15:0] ctrl_q;
    reg [15:0] ctrl_d;
    reg wrPend_q;
    reg rdPend_q;
    reg [7:0] addr_q;
    reg syncMeta_q;
    reg syncSync_q;
    reg syncPrev_q;
    reg faultMeta_q;
    reg faultSync_q;
    wire addrPhase;
    wire hit;
    wire syncRise;

    // One-hot code to ratio; unlisted codes fall back to 1x and flag it
    function [5:0] dacmc_ratio;
        input [3:0] code;
        begin
            case (code)
                `DACMC_INTERP_1X: dacmc_ratio = {1'b0, 5'd1};
                `DACMC_INTERP_2X: dacmc_ratio = {1'b0, 5'd2};
                `DACMC_INTERP_4X: dacmc_ratio = {1'b0, 5'd4};
                `DACMC_INTERP_8X: dacmc_ratio = {1'b0, 5'd8};
                `DACMC_INTERP_16X: dacmc_ratio = {1'b0, 5'd16};
                default: dacmc_ratio = {1'b1, 5'd1};
            endcase
        end
    endfunction

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = hsel & hready & htrans[1];
    assign hit = (addr_q == `DACMC_CTRL_OFFSET);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wrPend_q <= addrPhase & hwrite;
            rdPend_q <= addrPhase & ~hwrite;
            if (addrPhase) begin
                addr_q <= {haddr[7:2], 2'b00};
            end
        end
    end

    // Reserved bits are masked so they stay zero whatever is written
    always @* begin
        ctrl_d = ctrl_q;
        if (wrPend_q && hit) begin
            ctrl_d = hwdata[15:0] & `DACMC_CTRL_WMASK;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `DACMC_CTRL_RESET;
            hrdata <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            if (addrPhase && !hwrite) begin
                hrdata <= ({haddr[7:2], 2'b00} == `DACMC_CTRL_OFFSET) ?
                    {16'h0000, ctrl_d} : 32'h00000000;
            end
        end
    end

    // Decoded controls, registered: one cycle after the register changes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qmcOffsetEn <= 1'b0;
            qmcCorrEn <= 1'b0;
            interpRatio <= 5'd8;
            interpBad <= 1'b0;
            fifoEn <= 1'b1;
            invSincEn <= 1'b0;
        end else begin
            qmcOffsetEn <= ctrl_q[`DACMC_BIT_QMC_OFFSET];
            qmcCorrEn <= ctrl_q[`DACMC_BIT_QMC_CORR];
            {interpBad, interpRatio} <= dacmc_ratio(
                ctrl_q[`DACMC_INTERP_HI:`DACMC_INTERP_LO]);
            fifoEn <= ctrl_q[`DACMC_BIT_FIFO];
            invSincEn <= ctrl_q[`DACMC_BIT_INVSINC];
        end
    end

    // Fault pin: polarity then tri-state control, enable low drives
    assign faultOut = ctrl_q[`DACMC_BIT_FAULT_POL] ?
        faultSync_q : ~faultSync_q;
    assign faultOutEn_n = ~ctrl_q[`DACMC_BIT_FAULT_OE];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta_q <= 1'b0;
            syncSync_q <= 1'b0;
            syncPrev_q <= 1'b0;
            faultMeta_q <= 1'b0;
            faultSync_q <= 1'b0;
        end else begin
            syncMeta_q <= syncIn;
            syncSync_q <= syncMeta_q;
            syncPrev_q <= syncSync_q;
            faultMeta_q <= faultIn;
            faultSync_q <= faultMeta_q;
        end
    end

    assign syncRise = syncSync_q & ~syncPrev_q;

    // Two divider phase counters stand for the divided clocks; a sync
    // clears both together so they stay aligned afterwards
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div0Phase <= {DIV_WIDTH{1'b0}};
            div1Phase <= {DIV_WIDTH{1'b0}};
            syncSeen <= 1'b0;
        end else if (syncRise && ctrl_q[`DACMC_BIT_DIV_SYNC]) begin
            div0Phase <= {DIV_WIDTH{1'b0}};
            div1Phase <= {DIV_WIDTH{1'b0}};
            syncSeen <= 1'b1;
        end else begin
            div0Phase <= div0Phase + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
            div1Phase <= div1Phase + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
            syncSeen <= 1'b0;
        end
    end
endmodule

// ===== tb/dacmc_main_control_chk.sv
// Checker for the main control register outputs.
// Sees only the top ports; bound from the bench.
`timescale 1ns/1ps
module dacmc_main_control_chk (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire faultIn,
    input wire faultOut,
    input wire faultOutEn_n,
    input wire qmcOffsetEn,
    input wire qmcCorrEn,
    input wire [4:0] interpRatio,
    input wire fifoEn,
    input wire invSincEn
);
    reg wrPh_q;
    reg [15:0] wrD_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            wrPh_q <= 1'b0;
        else
            wrPh_q <= hsel & hready & htrans[1] & hwrite & ~|haddr[7:2];
    end
    // Data kept only for the data phase of a register write
    always @(posedge clk) begin
        if (wrPh_q)
            wrD_q <= hwdata[15:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_value: assert property ($rose(rst_n) |->
        interpRatio == 5'h08 && fifoEn && !faultOutEn_n && !invSincEn)
        else $error("outputs wrong after reset");
    // Decoded controls follow the register by one more edge
    a_offset_en: assert property (wrPh_q |=> ##1 qmcOffsetEn == wrD_q[15])
        else $error("offset enable wrong");
    a_corr_en: assert property (wrPh_q |=> ##1 qmcCorrEn == wrD_q[13])
        else $error("phase gain enable wrong");
    a_interp_map: assert property (wrPh_q |=> ##1 interpRatio ==
        ($onehot(wrD_q[11:8]) ? {wrD_q[11:8], 1'b0} : 5'h01))
        else $error("interpolation ratio wrong");
    a_fifo_en: assert property (wrPh_q |=> ##1 fifoEn == wrD_q[7])
        else $error("fifo enable wrong");
    a_fault_drive: assert property (wrPh_q |=> faultOutEn_n != wrD_q[4])
        else $error("fault drive wrong");
    // Fault input must be steady so the two sync stages agree
    a_fault_pol: assert property (wrPh_q && faultIn == $past(faultIn)
        && faultIn == $past(faultIn, 2) |=> faultOut == (wrD_q[3] ~^ $past(faultIn)))
        else $error("fault polarity wrong");
    a_invsinc_en: assert property (wrPh_q |=> ##1 invSincEn == wrD_q[1])
        else $error("inverse sinc enable wrong");
    cover property (wrPh_q);
    cover property ($fell(faultOutEn_n));
    cover property (interpRatio == 5'h10);
endmodule

// ===== tb/dacmc_main_control_bench.sv
// Bench for the main control register over AHB-Lite.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failCount++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dacmc_main_control_bench;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, syncIn = 0, faultIn = 1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    wire hreadyout, hresp, faultOut, faultOutEn_n, qmcOffsetEn, qmcCorrEn;
    wire interpBad, fifoEn, invSincEn, syncSeen, hready = hreadyout;
    wire [4:0] interpRatio;
    wire [3:0] div0Phase, div1Phase;
    int failCount = 0, comparisons = 0, cycles = 0;
    dacmc_main_control dacmc_main_control_inst (.*);
    always #50 clk = ~clk; // One clock serves sample and word side
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            finalReport();
        end
    end
    task automatic finalReport;
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One single transfer; returns just after the data phase edge
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic testFields;
        logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
        logic [4:0] rat [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h01};
        logic [15:0] v;
        for (int i = 0; i < 6; i++) begin
            v = (i[0] ? 16'hF0FF : 16'h4071) | {4'h0, codes[i], 8'h00};
            ahb(1'b1, '0, {16'h0000, v & 16'hAF9E});
            @(posedge clk);
            @(negedge clk);
            `CHK({qmcOffsetEn, qmcCorrEn}, {v[15], v[13]})
            `CHK({fifoEn, invSincEn}, {v[7], v[1]})
            `CHK({faultOutEn_n, faultOut}, {~v[4], v[3]})
            `CHK(interpRatio, rat[i])
            ahb(1'b0, '0, '0);
            `CHK(r, {16'h0000, v & 16'hAF9E})
        end
        $display("field test done");
    endtask
    task automatic testSync;
        logic seen;
        for (int e = 1; e >= 0; e--) begin
            ahb(1'b1, '0, e << 2);
            seen = 1'b0;
            syncIn <= 1'b1;
            repeat (8) begin
                @(negedge clk);
                if (syncSeen === 1'b1) begin
                    seen = 1'b1;
                    `CHK(div0Phase, div1Phase)
                    `CHK(div0Phase, 4'h0)
                end
            end
            @(posedge clk);
            syncIn <= 1'b0;
            `CHK(seen, e[0])
        end
        $display("sync test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        ahb(1'b0, '0, '0);
        `CHK(r, 32'h0000049C)
        `CHK(interpRatio, 5'h08)
        $display("reset test done");
        testFields();
        // Unmapped word: write dropped, read zero, register untouched
        ahb(1'b1, 32'h4, '1);
        ahb(1'b0, 32'h4, '0);
        `CHK(r, 32'h0)
        ahb(1'b0, '0, '0);
        `CHK(r, 32'h0000A39E)
        $display("unmapped test done");
        testSync();
        finalReport();
    end
endmodule
bind dacmc_main_control dacmc_main_control_chk dacmc_main_control_chk_inst (.*);
